// ==== clw_defs.vh ====
// constants for the serial link loss watchdog
// assumes the includer runs at 200 MHz and the interval setting is in 0.1 s units
`ifndef CLW_DEFS_VH
`define CLW_DEFS_VH
`define CLW_CLK_HZ          200000000
`define CLW_TICK_MS         100
`define CLW_TICK_CYCLES     ((`CLW_CLK_HZ / 1000) * `CLW_TICK_MS)
`define CLW_INTERVAL_OFF    14'h270F
`define CLW_INTERVAL_NOW    14'h0000
`define CLW_INTERVAL_MAX    14'h270E
`define CLW_COUNT_RESET     16'h0000
`define CLW_SEL_FIRST       8'hBE
`define CLW_SEL_LAST        8'hC4
`define CLW_TERMINALS       7
`endif

// ==== clw_tick_gen.v ====
// 0.1 s time base for the loss watchdog
// assumes one free running system clock; restarts whenever clear is high
`timescale 1ns/1ps
`default_nettype none
module clw_tick_gen #(
  parameter integer TICK_CYCLES = 20000000
) (
  input  wire clk_sys,
  input  wire sys_rst,
  input  wire clear,
  output reg  tick
);
  reg [31:0] count;

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      count <= 32'h00000000;
      tick  <= 1'b0;
    end else if (clear) begin
      count <= 32'h00000000;
      tick  <= 1'b0;
    end else if (count == TICK_CYCLES - 1) begin
      count <= 32'h00000000;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h00000001;
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== clw_comm_loss_watchdog.v ====
// serial link supervision: error counter, error alarm and loss-of-signal trip
// assumes frame and error strobes are one-cycle pulses from the link receiver
`timescale 1ns/1ps
`default_nettype none
`include "clw_defs.vh"
module clw_comm_loss_watchdog #(
  parameter integer TICK_CYCLES = `CLW_TICK_CYCLES,
  parameter integer COUNT_W     = 16
) (
  input  wire               clk_sys,
  input  wire               sys_rst,
  input  wire               driveReset,
  input  wire               frameReceived,
  input  wire               commErrorEvent,
  input  wire               commErrorActive,
  input  wire               networkMode,
  input  wire [13:0]        linkCheckIntervalSetting,
  input  wire [7:0]         outputTerminalFunctionSelect0,
  input  wire [7:0]         outputTerminalFunctionSelect1,
  input  wire [7:0]         outputTerminalFunctionSelect2,
  input  wire [7:0]         outputTerminalFunctionSelect3,
  input  wire [7:0]         outputTerminalFunctionSelect4,
  input  wire [7:0]         outputTerminalFunctionSelect5,
  input  wire [7:0]         outputTerminalFunctionSelect6,
  input  wire [7:0]         commErrorAlarmCode,
  output reg  [COUNT_W-1:0] commErrorCountSetting,
  output reg                commErrorAlarmOut,
  output reg  [6:0]         terminalOutputEnable,
  output reg                serialCommFaultTrip,
  output reg                supervising
);
  // one-hot: idle, armed waiting for the first frame, watching the interval
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_ARMED = 3'b010;
  localparam [2:0] ST_WATCH = 3'b100;

  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [13:0] elapsed;
  reg         prevNetwork;
  wire        tick;
  // the two reserved settings are decoded once; everything else is an interval
  wire        checkOff  = (linkCheckIntervalSetting == `CLW_INTERVAL_OFF);
  wire        checkNow  = (linkCheckIntervalSetting == `CLW_INTERVAL_NOW);
  wire        enterNet  = networkMode & ~prevNetwork;
  // the time base restarts on every frame and whenever timing is not running
  wire        restartTick = frameReceived | driveReset | (state != ST_WATCH);
  wire        intervalUsed;
  wire        tripOnEntry;
  wire        tripOnLoss;
  reg  [6:0]  next_terminalOutputEnable;
  reg  [13:0] next_elapsed;
  reg  [COUNT_W-1:0] next_commErrorCountSetting;

  // open-collector transistor on: enable high when the alarm code is selected
  function sel_hit;
    input [7:0] sel;
    input [7:0] code;
    begin
      sel_hit = (sel == code);
    end
  endfunction

  // one tick per setting step; elapsed counts ticks, not clocks
  clw_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clear  (restartTick),
    .tick   (tick)
  );

  // saturate rather than wrap so a flood of errors never looks like few
  always @* begin
    next_commErrorCountSetting = commErrorCountSetting;
    if (commErrorEvent && ~&commErrorCountSetting) begin
      next_commErrorCountSetting = commErrorCountSetting + {{(COUNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      commErrorCountSetting <= `CLW_COUNT_RESET;
    end else if (driveReset) begin
      commErrorCountSetting <= `CLW_COUNT_RESET;
    end else begin
      commErrorCountSetting <= next_commErrorCountSetting;
    end
  end

  // a terminal's transistor conducts only while its selection names the alarm
  always @* begin
    next_terminalOutputEnable = 7'h00;
    if (commErrorActive) begin
      next_terminalOutputEnable[0] = sel_hit(outputTerminalFunctionSelect0, commErrorAlarmCode);
      next_terminalOutputEnable[1] = sel_hit(outputTerminalFunctionSelect1, commErrorAlarmCode);
      next_terminalOutputEnable[2] = sel_hit(outputTerminalFunctionSelect2, commErrorAlarmCode);
      next_terminalOutputEnable[3] = sel_hit(outputTerminalFunctionSelect3, commErrorAlarmCode);
      next_terminalOutputEnable[4] = sel_hit(outputTerminalFunctionSelect4, commErrorAlarmCode);
      next_terminalOutputEnable[5] = sel_hit(outputTerminalFunctionSelect5, commErrorAlarmCode);
      next_terminalOutputEnable[6] = sel_hit(outputTerminalFunctionSelect6, commErrorAlarmCode);
    end
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      commErrorAlarmOut <= 1'b0;
    end else begin
      commErrorAlarmOut <= commErrorActive;
    end
  end

  // more than one terminal may carry the alarm; each follows its own selection
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      terminalOutputEnable <= 7'h00;
    end else begin
      terminalOutputEnable <= next_terminalOutputEnable;
    end
  end

  // leaving network mode or switching checking off drops back to idle, so a
  // re-entry waits for a fresh first frame before timing again
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (enterNet && !checkOff && !checkNow) begin
          next_state = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (!networkMode || checkOff) begin
          next_state = ST_IDLE;
        end else if (frameReceived) begin
          next_state = ST_WATCH;
        end
      end
      ST_WATCH: begin
        if (!networkMode || checkOff) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // widened by one bit so the compare can never wrap
  assign intervalUsed = ({1'b0, elapsed} + 15'h0001 >= {1'b0, linkCheckIntervalSetting});
  assign tripOnEntry  = enterNet & checkNow;
  assign tripOnLoss   = (state == ST_WATCH) & ~checkOff & tick & intervalUsed &
                        ~frameReceived;

  // frame restarts the count whatever station it addresses; the silent
  // gap before a query counts toward the interval, so the master must
  // allow for it at low baud rates
  always @* begin
    next_elapsed = elapsed;
    if (frameReceived || state != ST_WATCH) begin
      next_elapsed = 14'h0000;
    end else if (tick && elapsed != 14'h3FFF) begin
      next_elapsed = elapsed + 14'h0001;
    end
  end

  // a drive reset returns the supervision to idle like power-up
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
    end else if (driveReset) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // sampled through a drive reset too, so staying in network mode is no new entry
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prevNetwork <= 1'b0;
    end else begin
      prevNetwork <= networkMode;
    end
  end

  // high from the cycle after the first frame while the interval is timed
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      supervising <= 1'b0;
    end else if (driveReset) begin
      supervising <= 1'b0;
    end else begin
      supervising <= (next_state == ST_WATCH);
    end
  end

  // elapsed setting steps since the last frame
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      elapsed <= 14'h0000;
    end else if (driveReset) begin
      elapsed <= 14'h0000;
    end else begin
      elapsed <= next_elapsed;
    end
  end

  // the trip is latched: only a reset brings the drive back, never a late
  // frame, so a master that recovers cannot mask a lost link
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      serialCommFaultTrip <= 1'b0;
    end else if (driveReset) begin
      serialCommFaultTrip <= 1'b0;
    end else if (tripOnEntry || tripOnLoss) begin
      serialCommFaultTrip <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== clw_wd_sva.sv ====
// assertions on the watchdog ports
// assumes a bind onto clw_comm_loss_watchdog
`timescale 1ns/1ps
`default_nettype none
module clw_wd_sva #(parameter integer COUNT_W = 16) (
  input wire logic               clk_sys,
  input wire logic               sys_rst,
  input wire logic               driveReset,
  input wire logic               frameReceived,
  input wire logic               commErrorEvent,
  input wire logic               commErrorActive,
  input wire logic               networkMode,
  input wire logic               commErrorAlarmOut,
  input wire logic               serialCommFaultTrip,
  input wire logic               supervising,
  input wire logic [6:0]         terminalOutputEnable,
  input wire logic [13:0]        linkCheckIntervalSetting,
  input wire logic [COUNT_W-1:0] commErrorCountSetting
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_count_step: assert property (commErrorEvent && !driveReset && !(&commErrorCountSetting)
    |=> commErrorCountSetting == $past(commErrorCountSetting) + 1'b1) else $error("count step");
  chk_count_hold: assert property (!commErrorEvent && !driveReset
    |=> $stable(commErrorCountSetting)) else $error("count moved");
  chk_reset_clear: assert property (driveReset
    |=> commErrorCountSetting == '0 && !serialCommFaultTrip) else $error("reset clear");
  chk_alarm_follow: assert property (!$past(sys_rst) && !$past(driveReset)
    |-> commErrorAlarmOut == $past(commErrorActive)) else $error("alarm level");
  chk_fault_latch: assert property (serialCommFaultTrip && !driveReset
    |=> serialCommFaultTrip) else $error("fault dropped");
  chk_zero_trip: assert property (!$past(sys_rst) && $rose(networkMode) && !driveReset
    && linkCheckIntervalSetting == 14'h0000 |=> serialCommFaultTrip) else $error("zero trip");
  chk_off_quiet: assert property (linkCheckIntervalSetting == 14'h270F && !serialCommFaultTrip
    |=> !serialCommFaultTrip) else $error("trip while off");
  chk_start_frame: assert property ($rose(supervising) |-> $past(frameReceived))
    else $error("watch began early");
  chk_route_off: assert property (!$past(commErrorActive)
    |-> terminalOutputEnable == 7'h00) else $error("route while idle");
  cover property ($rose(commErrorAlarmOut));
  cover property ($rose(serialCommFaultTrip));
  cover property ($rose(supervising));
  cover property (commErrorEvent);
endmodule
bind clw_comm_loss_watchdog clw_wd_sva #(.COUNT_W(COUNT_W)) i_clw_wd_sva (.*);
`default_nettype wire

// ==== clw_master_model.sv ====
// stand-in for the network master: one frame strobe every gap+1 cycles
// assumes the bench starts and stops it at clock edges
`timescale 1ns/1ps
`default_nettype none
module clw_master_model (
  input wire logic        clk_sys,
  input wire logic        run,
  input wire logic [15:0] gap,
  output var logic        frameReceived
);
  logic [15:0] cnt = 16'h0000;
  initial frameReceived = 1'b0;
  // gap covers frame time plus the 3.5 byte silence, so it must stay under the interval
  always @(posedge clk_sys) begin
    cnt <= (run && cnt < gap) ? cnt + 16'h0001 : 16'h0000;
    frameReceived <= run && cnt == gap;
  end
endmodule
`default_nettype wire

// ==== clw_comm_loss_watchdog_tb.sv ====
// self-checking bench for the link loss watchdog
// assumes a 10 cycle tick, so one setting step is 10 clocks
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) n_tests++; if ((a) !== (b)) begin num_errors++; $display("ERROR %0t mismatch", $time); end
module clw_comm_loss_watchdog_tb;
  logic clk_sys = 1'b0, sys_rst = 1'b1, driveReset = 1'b0, commErrorEvent = 1'b0;
  logic commErrorActive = 1'b0, networkMode = 1'b0, run = 1'b0, frameReceived;
  logic alarm, fault, supervising;
  logic [13:0] setting = 14'h0000;
  logic [15:0] gap = 16'h001D, count;
  logic [7:0] selA = 8'h00, selB = 8'h00, selC = 8'h00, code = 8'hBE;
  logic [6:0] termEn;
  int num_errors = 0, n_tests = 0, n;
  always #2.5 clk_sys = ~clk_sys;
  clw_master_model i_clw_master_model (.clk_sys(clk_sys), .run(run), .gap(gap),
    .frameReceived(frameReceived));
  clw_comm_loss_watchdog #(.TICK_CYCLES(10)) i_clw_comm_loss_watchdog (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .driveReset(driveReset), .frameReceived(frameReceived),
    .commErrorEvent(commErrorEvent), .commErrorActive(commErrorActive), .networkMode(networkMode),
    .linkCheckIntervalSetting(setting), .outputTerminalFunctionSelect0(selA),
    .outputTerminalFunctionSelect1(8'h01), .outputTerminalFunctionSelect2(8'h02),
    .outputTerminalFunctionSelect3(selB), .outputTerminalFunctionSelect4(8'h04),
    .outputTerminalFunctionSelect5(selC), .outputTerminalFunctionSelect6(selC),
    .commErrorAlarmCode(code), .commErrorCountSetting(count), .commErrorAlarmOut(alarm),
    .terminalOutputEnable(termEn), .serialCommFaultTrip(fault), .supervising(supervising));
  task cyc(input int k); repeat (k) @(posedge clk_sys); endtask
  task dreset; cyc(1); driveReset <= 1'b1; cyc(1); driveReset <= 1'b0; endtask
  task report_and_stop;
    if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    cyc(10); sys_rst <= 1'b0;
    cyc(1); #1 `CHK(count, 16'h0000)
    cyc(1); commErrorEvent <= 1'b1; cyc(3); commErrorEvent <= 1'b0;
    cyc(1); #1 `CHK(count, 16'h0003)
    dreset; cyc(1); #1 `CHK(count, 16'h0000)
    cyc(1); commErrorActive <= 1'b1; selA <= code; selB <= code; selC <= code;
    cyc(2); #1 `CHK(alarm, 1'b1)
    `CHK(termEn, 7'h69)
    cyc(1); commErrorActive <= 1'b0; cyc(2); #1 `CHK(termEn, 7'h00)
    `CHK(alarm, 1'b0)
    cyc(1); networkMode <= 1'b1; cyc(2); #1 `CHK(fault, 1'b1)
    cyc(6); #1 `CHK(fault, 1'b1)
    cyc(1); networkMode <= 1'b0; dreset; cyc(1); #1 `CHK(fault, 1'b0)
    cyc(1); setting <= 14'h0005; networkMode <= 1'b1;
    cyc(100); #1 `CHK(fault, 1'b0)
    cyc(1); run <= 1'b1; cyc(300); #1 `CHK(fault, 1'b0)
    `CHK(supervising, 1'b1)
    cyc(1); run <= 1'b0; n = 0;
    while (fault !== 1'b1 && n < 90) begin cyc(1); #1 n++; end
    `CHK(n > 15 && n < 56, 1'b1)
    if (n >= 90) report_and_stop;
    cyc(1); networkMode <= 1'b0; setting <= 14'h270F; dreset;
    cyc(1); networkMode <= 1'b1; run <= 1'b1; cyc(40); run <= 1'b0;
    cyc(200); #1 `CHK(fault, 1'b0)
    `CHK(supervising, 1'b0)
    report_and_stop;
  end
endmodule
`default_nettype wire
